// ### logic/gpio_pkg.sv
// Package of register offsets, reset values and widths for the I/O port.
package gpio_pkg;
   // ****************************************************************
   // Register map, one aligned word per register, ports 0x40 apart up to port 3; port 4 at 0xE0.
   // ****************************************************************
   localparam int unsigned port_stride = 32'h0000_0040;
   localparam logic [5:0] pin_value_off = 6'h00;
   localparam logic [5:0] output_latch_off = 6'h04;
   localparam logic [5:0] direction_off = 6'h08;
   localparam logic [5:0] analog_select_off = 6'h0C;
   localparam logic [5:0] weak_pullup_off = 6'h10;
   localparam logic [5:0] input_threshold_off = 6'h14;
   localparam logic [5:0] slew_limit_off = 6'h18;
   localparam logic [5:0] open_drain_off = 6'h1C;
   localparam logic [5:0] change_rise_off = 6'h20;
   localparam logic [5:0] change_fall_off = 6'h24;
   localparam logic [5:0] change_flag_off = 6'h28;
   localparam logic [5:0] serial_bus_pad_off = 6'h2C;
   localparam logic [5:0] periph_enable_off = 6'h30;

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [7:0] latch_rst = 8'h00;
   localparam logic [7:0] direction_rst = 8'hFF;
   localparam logic [7:0] analog_rst = 8'hFF;
   localparam logic [7:0] pullup_rst = 8'h00;
   localparam logic [7:0] threshold_rst = 8'hFF;
   localparam logic [7:0] slew_rst = 8'hFF;
   localparam logic [7:0] open_drain_rst = 8'h00;
   localparam logic [7:0] zero_rst = 8'h00;

   // ****************************************************************
   // Bus answers.
   // ****************************************************************
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;
   localparam int unsigned pin_width = 8;
   localparam int unsigned max_ports = 5;
endpackage

// ### logic/gpio_port_block.sv
// Multi-port general purpose I/O block behind an AXI4-Lite slave.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// How it works
// - Pin value reads return sampled pins; writes go to the output latch.
// - Every port write is read-modify-write into the output latch.
// - Latch holds last write from latch or pin value register, alike.
// - Output latch reads return stored latch, not pin levels.
// - Direction 1 disables the driver; 0 drives the latch bit out.
// - Direction bits control drivers even for analog input pins.
// - Analog select forces digital input to 0 for reads and peripherals.
// - Analog select does not affect any output function.
// - Analog select bits reset to analog mode.
// - Weak pull-up bit 1 enables, 0 disables, per pin.
// - Threshold bit selects Schmitt or TTL for reads and change detect.
// - Slew bit 1 limits slew rate, 0 gives maximum rate.
// - Open-drain bit 1 sinks only, 0 is push-pull.
// - Each pin may flag a rising or falling edge as change event.
// - Serial-bus pads have per-pad slew, pull-up, threshold controls.
// - Enabled peripheral owns the output; pin stays readable.
// - After reset outputs come from the latch; others via routing.
// - Enabled analog output beats digital and floats the driver.
// - Priority: configuration functions, analog out, peripheral routing, latch.
// - Bits of unimplemented pins read as 0.
// - Pull-up is off while the driver is enabled; stored bit kept.
module gpio_port_block #(
   parameter int unsigned num_ports = 3,
   parameter logic [39:0] pin_mask = 40'hFF_FF_FF_FF_FF
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [8*num_ports-1:0] pin_st_in,
   input wire logic [8*num_ports-1:0] pin_ttl_in,
   input wire logic [8*num_ports-1:0] pin_bus_in,
   input wire logic [8*num_ports-1:0] config_fn_en,
   input wire logic [8*num_ports-1:0] config_fn_out,
   input wire logic [8*num_ports-1:0] config_fn_oe,
   input wire logic [8*num_ports-1:0] analog_out_en,
   input wire logic [8*num_ports-1:0] periph_out,
   input wire logic [8*num_ports-1:0] periph_oe,
   output logic [8*num_ports-1:0] pin_out,
   output logic [8*num_ports-1:0] pin_oe,
   output logic [8*num_ports-1:0] pullup_en,
   output logic [8*num_ports-1:0] slew_limit_en,
   output logic [8*num_ports-1:0] bus_slew_en,
   output logic [8*num_ports-1:0] digital_in_en,
   output logic [8*num_ports-1:0] periph_in,
   output logic [8*num_ports-1:0] change_event
);
   localparam int unsigned nb = 8 * num_ports;
   // ****************************************************************
   // Parameter check.
   // ****************************************************************
   // ports per variant
   if (num_ports < 1 || num_ports > gpio_pkg::max_ports)
   begin : g_bad
      $error("num_ports must be 1 to 5");
   end

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   // Byte merge under strobe, used by every writable register but the change flags.
   function automatic logic [7:0] merge(input logic [7:0] old_v, new_v,
                                        input logic strb);
      merge = strb ? new_v : old_v;
   endfunction

   // Port index from the address; the fourth window holds two ports.
   function automatic int unsigned port_of(input logic [7:0] a);
      port_of = int'(a[7:6]) + ((a[7:6] == 2'h3 && a[5]) ? 1 : 0);
   endfunction

   // Port 4 lives at the upper half of the fourth window.
   function automatic logic [5:0] off_of(input logic [7:0] a);
      off_of = (a[7:6] == 2'h3 && a[5]) ? {1'b0, a[4:0]} : a[5:0];
   endfunction

   // ****************************************************************
   // Registers and input synchronisers.
   // ****************************************************************
   logic [7:0] lat_r [num_ports];
   logic [7:0] dir_r [num_ports];
   logic [7:0] ans_r [num_ports];
   logic [7:0] wpu_r [num_ports];
   logic [7:0] lvl_r [num_ports];
   logic [7:0] slr_r [num_ports];
   logic [7:0] odc_r [num_ports];
   logic [7:0] rise_r [num_ports];
   logic [7:0] fall_r [num_ports];
   logic [7:0] flag_r [num_ports];
   logic [7:0] sbp_r [num_ports];
   logic [7:0] pen_r [num_ports];
   logic [nb-1:0] st_s1_r, st_s2_r, ttl_s1_r, ttl_s2_r, bus_s1_r, bus_s2_r;
   logic [nb-1:0] din;
   logic [nb-1:0] imp;

   assign imp = pin_mask[nb-1:0];
   // Two flops on every pad level before anything reads it.
   always_ff @(posedge aclk)
   begin
      st_s1_r <= pin_st_in;
      st_s2_r <= st_s1_r;
      ttl_s1_r <= pin_ttl_in;
      ttl_s2_r <= ttl_s1_r;
      bus_s1_r <= pin_bus_in;
      bus_s2_r <= bus_s1_r;
   end

   // Digital input per pin after threshold choice and analog gating.
   always_comb
   begin
      for (int i = 0; i < nb; i++)
      begin
         din[i] = lvl_r[i/8][i%8] ? st_s2_r[i] : ttl_s2_r[i];
         if (sbp_r[i/8][i%8])
            din[i] = bus_s2_r[i];
         if (ans_r[i/8][i%8] || !imp[i])
            din[i] = 1'b0;
      end
   end

   // ****************************************************************
   // AXI4-Lite write path: address and data taken in either order.
   // ****************************************************************
   logic aw_full_r, w_full_r;
   logic [7:0] aw_r;
   logic [7:0] wd_r;
   logic ws_r;
   logic do_wr;
   int unsigned wp;
   logic [5:0] wo;

   assign do_wr = aw_full_r && w_full_r && !bvalid;
   assign wp = port_of(aw_r);
   assign wo = off_of(aw_r);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_r <= 8'h00;
         wd_r <= 8'h00;
         ws_r <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= gpio_pkg::resp_okay;
      end
      else
      begin
         awready <= !aw_full_r && !awready && !(awvalid && awready);
         wready <= !w_full_r && !wready && !(wvalid && wready);
         if (awvalid && awready)
         begin
            aw_full_r <= 1'b1;
            aw_r <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full_r <= 1'b1;
            wd_r <= wdata[7:0];
            ws_r <= wstrb[0];
         end
         if (do_wr)
         begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wp < num_ports && wo <= gpio_pkg::periph_enable_off &&
                      wo[1:0] == 2'h0) ? gpio_pkg::resp_okay
                                        : gpio_pkg::resp_slverr;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Register writes; change flags set by hardware win over clears.
   always_ff @(posedge aclk)
   begin
      for (int p = 0; p < num_ports; p++)
      begin
         if (!aresetn)
         begin
            lat_r[p] <= gpio_pkg::latch_rst;
            dir_r[p] <= gpio_pkg::direction_rst;
            ans_r[p] <= gpio_pkg::analog_rst;
            wpu_r[p] <= gpio_pkg::pullup_rst;
            lvl_r[p] <= gpio_pkg::threshold_rst;
            slr_r[p] <= gpio_pkg::slew_rst;
            odc_r[p] <= gpio_pkg::open_drain_rst;
            rise_r[p] <= gpio_pkg::zero_rst;
            fall_r[p] <= gpio_pkg::zero_rst;
            flag_r[p] <= gpio_pkg::zero_rst;
            sbp_r[p] <= gpio_pkg::zero_rst;
            pen_r[p] <= gpio_pkg::zero_rst;
         end
         else
         begin
            if (do_wr && wp == p)
            begin
               unique case (wo)
                  gpio_pkg::pin_value_off,
                  gpio_pkg::output_latch_off:
                     lat_r[p] <= merge(lat_r[p], wd_r, ws_r) & imp[p*8+:8];
                  gpio_pkg::direction_off:
                     dir_r[p] <= merge(dir_r[p], wd_r, ws_r);
                  gpio_pkg::analog_select_off:
                     ans_r[p] <= merge(ans_r[p], wd_r, ws_r);
                  gpio_pkg::weak_pullup_off:
                     wpu_r[p] <= merge(wpu_r[p], wd_r, ws_r);
                  gpio_pkg::input_threshold_off:
                     lvl_r[p] <= merge(lvl_r[p], wd_r, ws_r);
                  gpio_pkg::slew_limit_off:
                     slr_r[p] <= merge(slr_r[p], wd_r, ws_r);
                  gpio_pkg::open_drain_off:
                     odc_r[p] <= merge(odc_r[p], wd_r, ws_r);
                  gpio_pkg::change_rise_off:
                     rise_r[p] <= merge(rise_r[p], wd_r, ws_r);
                  gpio_pkg::change_fall_off:
                     fall_r[p] <= merge(fall_r[p], wd_r, ws_r);
                  gpio_pkg::serial_bus_pad_off:
                     sbp_r[p] <= merge(sbp_r[p], wd_r, ws_r);
                  gpio_pkg::periph_enable_off:
                     pen_r[p] <= merge(pen_r[p], wd_r, ws_r);
                  default: ;
               endcase
            end
            flag_r[p] <= ((do_wr && wp == p && ws_r &&
                           wo == gpio_pkg::change_flag_off) ?
                          (flag_r[p] & ~wd_r) : flag_r[p])
                         | change_event[p*8+:8];
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read path, answer one cycle after the address.
   // ****************************************************************
   int unsigned rp;
   logic [5:0] ro;
   logic [7:0] rv;

   assign rp = port_of(araddr);
   assign ro = off_of(araddr);

   // Read data select; absent ports and offsets read zero.
   always_comb
   begin
      rv = 8'h00;
      if (rp < num_ports)
      begin
         unique case (ro)
            gpio_pkg::pin_value_off: rv = din[rp*8+:8];
            gpio_pkg::output_latch_off: rv = lat_r[rp];
            gpio_pkg::direction_off: rv = dir_r[rp];
            gpio_pkg::analog_select_off: rv = ans_r[rp];
            gpio_pkg::weak_pullup_off: rv = wpu_r[rp];
            gpio_pkg::input_threshold_off: rv = lvl_r[rp];
            gpio_pkg::slew_limit_off: rv = slr_r[rp];
            gpio_pkg::open_drain_off: rv = odc_r[rp];
            gpio_pkg::change_rise_off: rv = rise_r[rp];
            gpio_pkg::change_fall_off: rv = fall_r[rp];
            gpio_pkg::change_flag_off: rv = flag_r[rp];
            gpio_pkg::serial_bus_pad_off: rv = sbp_r[rp];
            gpio_pkg::periph_enable_off: rv = pen_r[rp];
            default: rv = 8'h00;
         endcase
         rv = rv & imp[rp*8+:8];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= gpio_pkg::resp_okay;
      end
      else
      begin
         arready <= !rvalid && !arready;
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rv};
            rresp <= (rp < num_ports && ro <= gpio_pkg::periph_enable_off &&
                      ro[1:0] == 2'h0) ? gpio_pkg::resp_okay
                                        : gpio_pkg::resp_slverr;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end

   // ****************************************************************
   // Pad drive, priority and edge detection.
   // ****************************************************************
   // Registered pad controls; the driver owner follows the priority chain.
   always_ff @(posedge aclk)
   begin
      for (int i = 0; i < nb; i++)
      begin
         logic dv, en;
         dv = 1'b0;
         en = 1'b0;
         if (!aresetn)
         begin
            pin_out[i] <= 1'b0;
            pin_oe[i] <= 1'b0;
            pullup_en[i] <= 1'b0;
            slew_limit_en[i] <= 1'b1;
            bus_slew_en[i] <= 1'b0;
            digital_in_en[i] <= 1'b0;
            periph_in[i] <= 1'b0;
            change_event[i] <= 1'b0;
         end
         else
         begin
            if (config_fn_en[i])
            begin
               dv = config_fn_out[i];
               en = config_fn_oe[i];
            end
            else if (analog_out_en[i])
               en = 1'b0;
            else if (pen_r[i/8][i%8])
            begin
               dv = periph_out[i];
               en = periph_oe[i];
            end
            else
            begin
               dv = lat_r[i/8][i%8];
               en = !dir_r[i/8][i%8];
            end
            // open drain sinks only; configuration functions keep drive
            if (odc_r[i/8][i%8] && dv && !config_fn_en[i])
               en = 1'b0;
            pin_out[i] <= dv & imp[i];
            pin_oe[i] <= en & imp[i];
            pullup_en[i] <= imp[i] && (wpu_r[i/8][i%8] ||
                             sbp_r[i/8][i%8]) && !en;
            slew_limit_en[i] <= slr_r[i/8][i%8] & imp[i];
            bus_slew_en[i] <= sbp_r[i/8][i%8] & imp[i];
            digital_in_en[i] <= !ans_r[i/8][i%8] & imp[i];
            periph_in[i] <= din[i]; // Also the edge detector's history.
            change_event[i] <= (rise_r[i/8][i%8] && din[i] && !periph_in[i])
                            || (fall_r[i/8][i%8] && !din[i] && periph_in[i]);
         end
      end
   end
endmodule

// ### testbench/gpio_pad_model.sv
// Behavioural model of the pads and the outside world on one port.
`timescale 1ns/1ps
module gpio_pad_model (
   input wire logic aclk,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] pullup_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ttl_flip,
   output logic [7:0] pin_st_in,
   output logic [7:0] pin_ttl_in,
   output logic [7:0] pin_bus_in
);
   logic [7:0] last_r;
   logic [7:0] lvl;

   // released pins follow outside, pull-up or float
   // A floating pin wanders away from its last level, never holds it.
   assign lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & (pullup_en | ~last_r));

   // Remember the level so a float can be made to drift.
   always_ff @(posedge aclk)
   begin
      last_r <= lvl;
   end

   // mid-level voltages read differently through the TTL buffer
   assign pin_st_in = lvl;
   assign pin_ttl_in = lvl ^ ttl_flip;
   assign pin_bus_in = lvl;
endmodule

// ### testbench/gpio_port_checker.sv
// Checker of bus and pad relations at the I/O port block ports.
`timescale 1ns/1ps
module gpio_port_checker #(
   parameter int unsigned num_ports = 3,
   parameter logic [39:0] pin_mask = 40'hFF_FF_FF_FF_FF
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [8*num_ports-1:0] config_fn_en,
   input wire logic [8*num_ports-1:0] config_fn_oe,
   input wire logic [8*num_ports-1:0] analog_out_en,
   input wire logic [8*num_ports-1:0] pin_oe,
   input wire logic [8*num_ports-1:0] pullup_en,
   input wire logic [8*num_ports-1:0] digital_in_en,
   input wire logic [8*num_ports-1:0] periph_in,
   input wire logic [8*num_ports-1:0] change_event
);
   // ****************************************************************
   // Properties, all in the one clock domain.
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Configuration drive term masked to pins that exist; absent pins never drive.
   // Both halves land in holding flops first, so the answer is two edges on.
   AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid
      && wready |=> !awready && !wready ##1 bvalid)
      else $error("write not answered");
   AST_WRITE_DONE: assert property (bvalid && bready |=> !bvalid)
      else $error("write answer held");
   AST_READ_ANSWER: assert property (arvalid && arready
      |=> rvalid && !arready) else $error("read not answered");
   AST_READ_DONE: assert property (rvalid && rready |=> !rvalid)
      else $error("read answer held");
   AST_UPPER_ZERO: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_PULLUP_OFF: assert property ((pullup_en & pin_oe) == '0)
      else $error("pull-up on a driven pin");
   AST_ANALOG_OUT: assert property ($past(aresetn) |-> (pin_oe
      & $past(analog_out_en) & ~$past(config_fn_en)) == '0)
      else $error("driver on under analog output");
   AST_CONFIG_FIRST: assert property ($past(aresetn) |-> ((pin_oe
      ^ $past(config_fn_oe)) & $past(config_fn_en)
      & pin_mask[8*num_ports-1:0]) == '0)
      else $error("configuration drive lost");
   AST_ANALOG_IN: assert property ((periph_in & ~digital_in_en) == '0)
      else $error("analog pin feeds peripheral");

   // Main scenarios reached.
   cover property (bvalid && bready && bresp == gpio_pkg::resp_slverr);
   cover property (rvalid && rready);
   cover property (change_event != '0);
   cover property (pullup_en != '0);
endmodule

bind gpio_port_block gpio_port_checker #(.num_ports(num_ports),
   .pin_mask(pin_mask)) chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid,
   .rready, .config_fn_en, .config_fn_oe, .analog_out_en, .pin_oe,
   .pullup_en, .digital_in_en, .periph_in, .change_event);

// ### testbench/test_general_purpose_io_port.sv
// Self-checking bench of the I/O port block with one port.
`timescale 1ns/1ps
module test_general_purpose_io_port;
   localparam logic [7:0] m = 8'h7F;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, ext_val, ext_en, ttl_flip, v, w;
   logic [31:0] wdata, rdata, seed, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [7:0] cfg_en, cfg_out, cfg_oe, aout, p_out, p_oe;
   logic [7:0] st, ttl, bus, pin_out, pin_oe, pullup_en, slew_limit_en;
   logic [7:0] bus_slew_en, digital_in_en, periph_in, change_event;
   logic [7:0] mdl [0:12];
   int failures, n_checks, cyc, i, n0, n1;

   // ****************************************************************
   // Clock, design and pads.
   // ****************************************************************
   initial
   begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end

   gpio_port_block #(.num_ports(1), .pin_mask(40'h00_00_00_00_7F)) dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .pin_st_in(st),
      .pin_ttl_in(ttl), .pin_bus_in(bus), .config_fn_en(cfg_en),
      .config_fn_out(cfg_out), .config_fn_oe(cfg_oe), .analog_out_en(aout),
      .periph_out(p_out), .periph_oe(p_oe), .pin_out, .pin_oe, .pullup_en,
      .slew_limit_en, .bus_slew_en, .digital_in_en, .periph_in,
      .change_event);

   gpio_pad_model pads (.aclk, .pin_out, .pin_oe, .pullup_en, .ext_val,
      .ext_en, .ttl_flip, .pin_st_in(st), .pin_ttl_in(ttl),
      .pin_bus_in(bus));

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string s, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Address and data go out together; each drops once taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      bit ta;
      bit tw;
      ta = 0;
      tw = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, dv};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ta && tw))
      begin
         @(posedge aclk);
         ta = ta | awready;
         tw = tw | wready;
         awvalid <= !ta;
         wvalid <= !tw;
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
      bready <= 0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask

   // Write a register and keep the model in step; pin value hits latch.
   task automatic wreg(input logic [5:0] x, input logic [7:0] dv);
      wr({x, 2'b00}, dv);
      chk("bresp", r, gpio_pkg::resp_okay);
      mdl[x == 0 ? 1 : x] = dv & m;
   endtask

   task automatic rreg(input logic [5:0] x, input logic [7:0] e);
      rd({x, 2'b00});
      chk("rresp", r, gpio_pkg::resp_okay);
      chk("rdata", d, {24'h0, e});
   endtask

   // A hang ends the run as a failure.
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         failures++;
         print_verdict();
      end
   end

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, ext_val, ttl_flip, cfg_en, cfg_out} = '0;
      {cfg_oe, aout, p_out, p_oe} = '0;
      wstrb = 4'hF;
      ext_en = 8'hFF;
      seed = 1;
      mdl = '{default: 8'h00};
      mdl[2] = gpio_pkg::direction_rst & m;
      mdl[3] = gpio_pkg::analog_rst & m;
      mdl[5] = gpio_pkg::threshold_rst & m;
      mdl[6] = gpio_pkg::slew_rst & m;
      tick(3);
      aresetn <= 1;
      for (i = 1; i < 10; i++)
         rreg(6'(i), mdl[i]);
      rd(8'h34);
      chk("unmapped", r, gpio_pkg::resp_slverr);
      chk("unmapped_data", d, 32'h0);
      wr(8'h40, 8'hAA);
      chk("absent", r, gpio_pkg::resp_slverr);
      for (i = 0; i < 8; i++)
      begin
         v = 8'(xs());
         wreg(6'(i % 2), v);
         rreg(1, mdl[1]);
      end
      // Byte strobe low leaves the latch as it was.
      wstrb <= 4'hE;
      wr(8'h04, 8'h00);
      wstrb <= 4'hF;
      rreg(1, mdl[1]);
      wreg(7, 0);
      wreg(3, 0);
      wreg(2, 8'hF0);
      wreg(4, 8'hFF);
      tick(2);
      chk("oe", pin_oe, 8'h0F);
      chk("out", pin_out & 8'h0F, mdl[1] & 8'h0F);
      chk("pull", pullup_en, 8'h70);
      rreg(4, m);
      wreg(3, 8'hFF);
      tick(2);
      chk("oe_an", pin_oe, 8'h0F);
      wreg(3, 0);
      wreg(2, 8'hFF);
      v = 8'(xs());
      ext_val <= v;
      ttl_flip <= 8'h0F;
      tick(4);
      rreg(0, v & m);
      wreg(5, 0);
      tick(4);
      rreg(0, (v ^ 8'h0F) & m);
      wreg(5, 8'hFF);
      wreg(3, 8'hFF);
      tick(4);
      rreg(0, 0);
      chk("pin_in", periph_in, 0);
      chk("din_en", digital_in_en, 0);
      wreg(3, 0);
      ext_val <= 8'h02;
      wreg(8, 8'h01);
      wreg(9, 8'h02);
      rd(8'h28);
      wr(8'h28, d[7:0]);
      n0 = 0;
      n1 = 0;
      ext_val <= 8'h01;
      for (i = 0; i < 10; i++)
      begin
         @(posedge aclk);
         n0 += change_event[0];
         n1 += change_event[1];
      end
      chk("edges", {n0[15:0], n1[15:0]}, {16'd1, 16'd1});
      rreg(10, 8'h03);
      wr(8'h28, 8'h03);
      rreg(10, 0);
      ext_en <= 0;
      wreg(2, 0);
      wreg(7, 8'hFF);
      wreg(1, 8'h55);
      tick(2);
      chk("od_oe", pin_oe, 8'h2A);
      chk("od_out", pin_out & pin_oe, 0);
      chk("od_pull", pullup_en, 8'h55);
      rreg(0, 8'h55);
      v = 8'(xs());
      wreg(6, v);
      wreg(11, 8'hFF);
      tick(2);
      chk("slew", slew_limit_en, v & m);
      chk("bus", bus_slew_en, m);
      wreg(11, 0);
      wreg(7, 0);
      wreg(12, 8'hFF);
      v = 8'(xs());
      w = 8'(xs());
      p_out <= v;
      p_oe <= 8'h33;
      ext_en <= 8'hCC;
      ext_val <= w;
      tick(4);
      chk("per_oe", pin_oe, 8'h33);
      chk("per_out", pin_out & 8'h33, v & 8'h33);
      rreg(0, ((v & 8'h33) | (w & 8'hCC)) & m);
      aout <= 8'h03;
      {cfg_en, cfg_oe, cfg_out} <= {3{8'h02}};
      tick(2);
      chk("prio_oe", pin_oe, 8'h32);
      chk("prio_out", pin_out[1], 1'b1);
      print_verdict();
   end
endmodule
